// ==== clfm_cfg.svh ====
`ifndef CLFM_CFG_SVH
`define CLFM_CFG_SVH
// Register byte offsets
`define CLFM_OFF_CTRL 12'h000
`define CLFM_OFF_STAT 12'h004
`define CLFM_OFF_IRQ 12'h008
`define CLFM_OFF_MASK 12'h00C
// Control field positions
`define CLFM_CTRL_MODE_LSB 0
`define CLFM_CTRL_RST 32'h0000_0000
// Interrupt bit positions
`define CLFM_IRQ_SET 0
`define CLFM_IRQ_CLR 1
`define CLFM_IRQ_THERM 2
`define CLFM_IRQ_W 3
// Timeouts in clock cycles, and synchroniser stage count
`define CLFM_BUS_DOM_CYC 1000
`define CLFM_TX_DOM_CYC 1000
`define CLFM_SYNC_STAGES 3
`endif

// ==== clfm_pkg.sv ====
package clfm_pkg;
  typedef enum logic [1:0] {
    CLFM_MODE_SLEEP,
    CLFM_MODE_STANDBY,
    CLFM_MODE_LISTEN,
    CLFM_MODE_NORMAL
  } clfm_mode_type;
  typedef enum logic [1:0] {
    CLFM_CAUSE_NONE,
    CLFM_CAUSE_BUS,
    CLFM_CAUSE_THERM,
    CLFM_CAUSE_TXD
  } clfm_cause_type;
endpackage : clfm_pkg

// ==== clfm_sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface clfm_sync_if;
  logic [2:0] raw;
  logic [2:0] clean;
  modport src (output raw, input clean);
  modport dst (input raw, output clean);
endinterface : clfm_sync_if
`default_nettype wire

// ==== clfm_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module clfm_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  clfm_sync_if.dst sif
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] clean_q;
  wire logic [2:0] agree = ~(s2_q ^ s3_q);
  wire logic [2:0] clean_d = (agree & s3_q) | (~agree & clean_q);
  // Start: recessive bus, recessive TXD, hot die
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 3'h3;
      s2_q <= 3'h3;
      s3_q <= 3'h3;
      clean_q <= 3'h3;
    end else if (ce) begin
      s1_q <= sif.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end
  assign sif.clean = clean_q;
endmodule : clfm_sync
`default_nettype wire

// ==== clfm_top.sv ====
// Overview of operation
// - Bus dominant longer than the bus timeout sets the local failure flag.
// - Bus-dominant fault alone leaves the transmitter enabled.
// - Bus-dominant-caused flag clears once the bus is recessive again.
// - Over-temperature indication sets the local failure flag.
// - Over-temperature disables the transmitter.
// - Transmitter stays off until temperature falls past hysteresis, then flag clears.
// - Receive dominant with transmit recessive clears flag and re-enables transmitter.
// - In listen-only mode the error output follows the cleared flag high.
// - Entering normal mode from another mode clears the flag.
// - Faults other than bus-dominant keep transmitter off until flag clears.
// - Transmit dominant past its timeout sets flag and disables transmitter.
// - Error output low shows a set flag after normal to listen-only.
`timescale 1ns/1ps
`default_nettype none
`include "clfm_cfg.svh"
module clfm_top #(
  parameter int BUS_DOM_CYC = `CLFM_BUS_DOM_CYC,
  parameter int TX_DOM_CYC = `CLFM_TX_DOM_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd_in,
  input wire logic bus_recessive_in,
  input wire logic over_temp_in,
  output logic rxd_out,
  output logic tx_drive_dominant,
  output logic err_n,
  output logic irq
);
  // over_temp_in: low above shutdown threshold, high once below threshold minus hysteresis
  logic [2:0] pin_clean;
  clfm_sync_if sif ();
  assign sif.raw = {over_temp_in, bus_recessive_in, txd_in};
  assign pin_clean = sif.clean;
  clfm_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sif(sif)
  );
  wire logic txd_rec = pin_clean[0];
  wire logic bus_rec = pin_clean[1];
  wire logic hot = ~pin_clean[2];
  // Pin is low while hot, so the synchroniser's reset value of 0 reads as hot
  wire logic over_temp = hot;

  function automatic logic [31:0] clfm_sat_inc(input logic [31:0] v, input logic clr);
    clfm_sat_inc = clr ? 32'h0000_0000 : ((v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001);
  endfunction : clfm_sat_inc

  clfm_pkg::clfm_mode_type mode_q;
  clfm_pkg::clfm_mode_type prev_mode_q;
  logic [31:0] bus_cnt_q;
  logic [31:0] tx_cnt_q;
  logic flag_q;
  logic tx_dis_q;
  logic bus_cause_q;
  logic therm_q;
  logic err_q;
  logic rxd_q;
  logic [3:0] ists_q;
  logic [3:0] imask_q;

  wire logic [31:0] bus_cnt_d = clfm_sat_inc(bus_cnt_q, bus_rec);
  wire logic [31:0] tx_cnt_d = clfm_sat_inc(tx_cnt_q, txd_rec);
  wire logic bus_to = (bus_cnt_q >= BUS_DOM_CYC);
  wire logic tx_to = (tx_cnt_q >= TX_DOM_CYC);
  wire logic enter_normal = (mode_q == clfm_pkg::CLFM_MODE_NORMAL) &&
                            (prev_mode_q != clfm_pkg::CLFM_MODE_NORMAL);
  wire logic rx_dom_tx_rec = ~rxd_q & txd_rec;
  wire logic hard_set = over_temp | tx_to;
  // Thermal blocks every clearing path until it has cooled past hysteresis
  wire logic clr_ok = ~over_temp;
  wire logic clr_req = clr_ok & (rx_dom_tx_rec | enter_normal | (bus_cause_q & ~tx_dis_q & bus_rec));
  wire logic therm_release = therm_q & ~over_temp & ~tx_to;
  wire logic set_any = hard_set | bus_to;
  // Set wins over clear
  wire logic flag_d = set_any | (flag_q & ~clr_req & ~therm_release);
  wire logic tx_dis_d = hard_set | (tx_dis_q & flag_d);
  wire logic bus_cause_d = (bus_to & ~hard_set) | (bus_cause_q & flag_d & ~tx_dis_d);
  wire logic listen = (mode_q == clfm_pkg::CLFM_MODE_LISTEN);
  wire logic from_normal = listen && (prev_mode_q == clfm_pkg::CLFM_MODE_NORMAL);
  logic show_q;
  wire logic show_d = from_normal ? 1'b1 : (listen ? show_q : 1'b0);
  wire logic err_d = ~((show_d & flag_d));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_cnt_q <= 32'h0000_0000;
      tx_cnt_q <= 32'h0000_0000;
      flag_q <= 1'b0;
      tx_dis_q <= 1'b0;
      bus_cause_q <= 1'b0;
      therm_q <= 1'b0;
      show_q <= 1'b0;
      err_q <= 1'b1;
      rxd_q <= 1'b1;
      prev_mode_q <= clfm_pkg::CLFM_MODE_STANDBY;
    end else if (ce) begin
      bus_cnt_q <= bus_cnt_d;
      tx_cnt_q <= tx_cnt_d;
      flag_q <= flag_d;
      tx_dis_q <= tx_dis_d;
      bus_cause_q <= bus_cause_d;
      therm_q <= over_temp | (therm_q & ~therm_release);
      show_q <= show_d;
      err_q <= err_d;
      rxd_q <= bus_rec;
      prev_mode_q <= mode_q;
    end
  end
  assign rxd_out = rxd_q;
  assign err_n = err_q;
  assign tx_drive_dominant = ~txd_rec & ~tx_dis_q;

  // AXI4-Lite slave
  logic aw_hold_q;
  logic w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic aw_have = aw_hold_q | aw_take;
  wire logic w_have = w_hold_q | w_take;
  wire logic [11:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire logic [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
  wire logic [3:0] ws = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire logic do_write = aw_have & w_have & ~bvalid_q & ce;
  wire logic wr_ctrl = do_write & (wa == `CLFM_OFF_CTRL) & ws[0];
  wire logic wr_irq = do_write & (wa == `CLFM_OFF_IRQ) & ws[0];
  wire logic wr_mask = do_write & (wa == `CLFM_OFF_MASK) & ws[0];
  wire logic wa_ok = (wa == `CLFM_OFF_CTRL) | (wa == `CLFM_OFF_STAT) |
                     (wa == `CLFM_OFF_IRQ) | (wa == `CLFM_OFF_MASK);
  wire logic ar_take = s_axi_arvalid & s_axi_arready & ce;
  wire logic ra_ok = (s_axi_araddr == `CLFM_OFF_CTRL) | (s_axi_araddr == `CLFM_OFF_STAT) |
                     (s_axi_araddr == `CLFM_OFF_IRQ) | (s_axi_araddr == `CLFM_OFF_MASK);
  wire logic [31:0] stat_word = {26'h0000000, bus_cause_q, therm_q, ~err_q, tx_dis_q, flag_q, mode_q == clfm_pkg::CLFM_MODE_NORMAL};
  wire logic [31:0] rd_mux =
    (s_axi_araddr == `CLFM_OFF_CTRL) ? {30'h00000000, mode_q} :
    (s_axi_araddr == `CLFM_OFF_STAT) ? stat_word :
    (s_axi_araddr == `CLFM_OFF_IRQ) ? {28'h0000000, ists_q} :
    (s_axi_araddr == `CLFM_OFF_MASK) ? {28'h0000000, imask_q} : 32'h0000_0000;
  wire logic [3:0] ev = {tx_to & ~flag_q, over_temp & ~therm_q, flag_q & ~flag_d, set_any & ~flag_q};
  wire logic [3:0] ists_d = ev | (ists_q & ~(wr_irq ? wd[3:0] : 4'h0));
  wire logic [1:0] mode_w = wd[1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      mode_q <= clfm_pkg::CLFM_MODE_STANDBY;
      ists_q <= 4'h0;
      imask_q <= 4'h0;
    end else if (ce) begin
      aw_hold_q <= aw_have & ~do_write;
      w_hold_q <= w_have & ~do_write;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wa_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= ra_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      if (wr_ctrl) begin
        mode_q <= clfm_pkg::clfm_mode_type'(mode_w);
      end
      if (wr_mask) begin
        imask_q <= wd[3:0];
      end
      ists_q <= ists_d;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = |(ists_q & imask_q);

  a_bus_keeps_tx: assert property (@(posedge aclk) disable iff (!aresetn)
    (bus_cause_q && !over_temp && !tx_to && !tx_dis_q) |-> (tx_drive_dominant == ~txd_rec))
    else $error("bus timeout disabled transmitter");
  a_therm_off_tx: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && over_temp) |=> tx_dis_q && !tx_drive_dominant)
    else $error("transmitter on during over temperature");
  a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && bus_to) |=> flag_q)
    else $error("bus timeout did not set flag");
  a_txd_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && tx_to) |=> (flag_q && tx_dis_q))
    else $error("transmit timeout missed");
  a_recover_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rx_dom_tx_rec && !set_any && !over_temp) |=> (!flag_q && !tx_dis_q))
    else $error("recovery did not clear flag");
  a_normal_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && enter_normal && !set_any) |=> !flag_q)
    else $error("entering normal did not clear flag");
  a_tx_until_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_dis_q && $past(tx_dis_q)) |-> $past(flag_q))
    else $error("transmitter disabled without flag");
  a_err_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && listen && show_q && $rose(flag_q == 1'b0)) |-> ##[0:1] err_n)
    else $error("error output not released");
  a_err_shows: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && from_normal && flag_d) |=> !err_n)
    else $error("error output not low for flag");
endmodule : clfm_top
`default_nettype wire

// ==== clfm_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Controller pin plus the bus wire; a clamp stands for a short that holds the bus dominant
module clfm_ctl_model (
  input wire logic txd_req,
  input wire logic bus_clamp,
  input wire logic tx_drive_dominant,
  output logic txd_in,
  output logic bus_recessive_in
);
  assign txd_in = txd_req;
  // Wired bus: any driver or the clamp makes it dominant
  assign bus_recessive_in = !(tx_drive_dominant || bus_clamp);
endmodule : clfm_ctl_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, txd_req, clamp, hot_n;
  logic txd, busr, rxd, txdd, err_n, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp;
  int err_total, n_tests, cyc_cnt;
  initial begin
    aclk = 1'h0;
    forever #2 aclk = !aclk;
  end
  clfm_top #(.BUS_DOM_CYC(8), .TX_DOM_CYC(8)) i_clfm_top (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .txd_in(txd), .bus_recessive_in(busr), .over_temp_in(hot_n),
    .rxd_out(rxd), .tx_drive_dominant(txdd), .err_n(err_n), .irq(irq));
  clfm_ctl_model i_clfm_ctl_model (.txd_req(txd_req), .bus_clamp(clamp), .tx_drive_dominant(txdd),
    .txd_in(txd), .bus_recessive_in(busr));
  task give_verdict;
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, ta, tw, bok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    // Handshakes are sampled mid-cycle, where they stand settled until the next rising edge
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      ta = !aw_ok && (awr === 1'h1);
      tw = !w_ok && (wr_rdy === 1'h1);
      @(posedge aclk);
      if (ta) begin
        aw_ok = 1'h1;
        awv <= 1'h0;
      end
      if (tw) begin
        w_ok = 1'h1;
        wv <= 1'h0;
      end
    end
    do begin
      @(negedge aclk);
      bok = (bv === 1'h1);
      @(posedge aclk);
    end while (!bok);
  endtask : wr
  task rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic ok;
    logic [31:0] dat;
    logic [1:0] rsp;
    ara <= a;
    arv <= 1'h1;
    do begin
      @(negedge aclk);
      ok = (arr === 1'h1);
      @(posedge aclk);
    end while (!ok);
    arv <= 1'h0;
    do begin
      @(negedge aclk);
      ok = (rv === 1'h1);
      dat = rdat;
      rsp = rresp;
      @(posedge aclk);
    end while (!ok);
    chk(dat & m, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : rdchk
  // A fault on the transmit pin: dominant past its timeout, then released
  task txd_fault;
    txd_req <= 1'h0;
    cyc(20);
    txd_req <= 1'h1;
    cyc(6);
  endtask : txd_fault
  // Brief clamp: bus dominant with transmit recessive, short of the bus timeout
  task rx_dom;
    clamp <= 1'h1;
    cyc(6);
    clamp <= 1'h0;
    cyc(6);
  endtask : rx_dom
  always @(posedge aclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    {aresetn, awv, wv, br, arv, rr, clamp} = 7'h0;
    {txd_req, hot_n} = 2'h3;
    {awa, ara, wd} = 56'h0;
    cyc(20);
    aresetn <= 1'h1;
    // Response ready stays high for the whole run
    br <= 1'h1;
    rr <= 1'h1;
    rdchk(12'h000, 32'h3, 32'h1, 2'h0);
    rdchk(12'h00C, 32'hF, 32'h0, 2'h0);
    rdchk(12'h010, 32'hFFFFFFFF, 32'h0, 2'h2);
    chk({31'h0, err_n}, 32'h1);
    wr(12'h000, 32'h3);
    wr(12'h004, 32'h0);
    rdchk(12'h004, 32'h1, 32'h1, 2'h0);
    clamp <= 1'h1;
    cyc(30);
    rdchk(12'h008, 32'h1, 32'h1, 2'h0);
    rdchk(12'h004, 32'h4, 32'h0, 2'h0);
    txd_req <= 1'h0;
    cyc(6);
    chk({31'h0, txdd}, 32'h1);
    txd_req <= 1'h1;
    clamp <= 1'h0;
    cyc(10);
    rdchk(12'h004, 32'h2, 32'h0, 2'h0);
    wr(12'h008, 32'hF);
    hot_n <= 1'h0;
    cyc(10);
    rdchk(12'h004, 32'h6, 32'h6, 2'h0);
    rdchk(12'h008, 32'h4, 32'h4, 2'h0);
    txd_req <= 1'h0;
    cyc(6);
    chk({31'h0, txdd}, 32'h0);
    txd_req <= 1'h1;
    rx_dom();
    rdchk(12'h004, 32'h6, 32'h6, 2'h0);
    hot_n <= 1'h1;
    cyc(10);
    rdchk(12'h004, 32'h6, 32'h0, 2'h0);
    wr(12'h008, 32'hF);
    txd_req <= 1'h0;
    cyc(20);
    chk({31'h0, txdd}, 32'h0);
    txd_req <= 1'h1;
    cyc(6);
    rdchk(12'h004, 32'h6, 32'h6, 2'h0);
    rdchk(12'h008, 32'h8, 32'h8, 2'h0);
    rx_dom();
    rdchk(12'h004, 32'h6, 32'h0, 2'h0);
    wr(12'h00C, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(12'h00C, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(12'h00C, 32'h2);
    wr(12'h008, 32'hF);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    txd_fault();
    wr(12'h000, 32'h2);
    cyc(3);
    chk({31'h0, err_n}, 32'h0);
    rx_dom();
    chk({31'h0, err_n}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    // Recovery without bus activity: listen, look, back to normal, look again
    wr(12'h000, 32'h3);
    txd_fault();
    wr(12'h000, 32'h2);
    cyc(3);
    chk({31'h0, err_n}, 32'h0);
    wr(12'h000, 32'h3);
    cyc(3);
    rdchk(12'h004, 32'h2, 32'h0, 2'h0);
    wr(12'h000, 32'h2);
    cyc(3);
    chk({31'h0, err_n}, 32'h1);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
